// ===== pmx_port_pin_mux.sv
`timescale 1ns/1ns
// Operation
// - Software picks normal, general I/O or second function for every shared pin on its own.
// - In normal function the owning peripheral drives enable and data and receives the pad level.
// - In general I/O function the general I/O logic drives the enable and the data out.
// - In second function the second peripheral drives data, and enable except on Port B pins 0 to 5, and receives the pad level.
// - Each pin has its own direction bit that governs it while in general I/O function.
// - Each pin has its own pull-up enable that acts in all three functions.
// - Ports B and C are covered and any of their pins may leave its normal peripheral.
// - Port B pins 0 to 5 carry the audio port signals in normal function and I/O lines 0 to 5 in general I/O function.
// - In second function Port B pins 0 to 5 drive radio test port signals 0 to 5.
// - The two radio control outputs each select one of three sources by a programmed role.
module pmx_port_pin_mux
    import pmx_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [13:0] port_b_pad_in,
    output logic [13:0] port_b_pad_out,
    output logic [13:0] port_b_pad_oe,
    output logic [13:0] port_b_pad_pull_en,
    input wire logic [13:0] port_b_norm_out,
    input wire logic [13:0] port_b_norm_oe,
    output logic [13:0] port_b_norm_in,
    input wire logic [13:6] port_b_alt2_out,
    input wire logic [13:6] port_b_alt2_oe,
    output logic [13:0] port_b_alt2_in,
    input wire logic [5:0] radio_test_port,
    input wire logic [12:0] port_c_pad_in,
    output logic [12:0] port_c_pad_out,
    output logic [12:0] port_c_pad_oe,
    output logic [12:0] port_c_pad_pull_en,
    input wire logic [12:0] port_c_norm_out,
    input wire logic [12:0] port_c_norm_oe,
    output logic [12:0] port_c_norm_in,
    input wire logic [12:0] port_c_alt2_out,
    input wire logic [12:0] port_c_alt2_oe,
    output logic [12:0] port_c_alt2_in,
    input wire logic transmit_enable,
    input wire logic amplifier_enable_out,
    input wire logic pulse_mod_out_0,
    input wire logic pulse_mod_out_1,
    output logic radio_ctrl_out_a,
    output logic radio_ctrl_out_b
);
    localparam int BFW = PMX_B_PINS * PMX_FUNC_W;
    localparam int CFW = PMX_C_PINS * PMX_FUNC_W;

    logic [BFW-1:0] b_func_reg;
    logic [BFW-1:0] b_func_next;
    logic [PMX_B_PINS-1:0] b_dir_reg;
    logic [PMX_B_PINS-1:0] b_dir_next;
    logic [PMX_B_PINS-1:0] b_pull_reg;
    logic [PMX_B_PINS-1:0] b_pull_next;
    logic [PMX_B_PINS-1:0] b_data_reg;
    logic [PMX_B_PINS-1:0] b_data_next;
    logic [CFW-1:0] c_func_reg;
    logic [CFW-1:0] c_func_next;
    logic [PMX_C_PINS-1:0] c_dir_reg;
    logic [PMX_C_PINS-1:0] c_dir_next;
    logic [PMX_C_PINS-1:0] c_pull_reg;
    logic [PMX_C_PINS-1:0] c_pull_next;
    logic [PMX_C_PINS-1:0] c_data_reg;
    logic [PMX_C_PINS-1:0] c_data_next;
    logic [PMX_RC_W-1:0] rc_reg;
    logic [PMX_RC_W-1:0] rc_next;
    logic wait_reg;
    logic wait_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] rd_word;
    logic [31:0] wr_word;
    logic [PMX_B_PINS-1:0] b_level;
    logic [PMX_C_PINS-1:0] c_level;
    logic [PMX_B_PINS-1:0] b_alt2_out_all;
    logic [PMX_B_PINS-1:0] b_alt2_oe_all;

    function automatic logic [31:0] pmx_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return m;
    endfunction : pmx_merge

    // Test port signals are output only, so their enable is held on.
    assign b_alt2_out_all = {port_b_alt2_out, radio_test_port};
    assign b_alt2_oe_all = {port_b_alt2_oe, PMX_TP_OE};

    always_comb begin
        case (avs_address)
            PMX_OFS_B_FUNC: rd_word = 32'(b_func_reg);
            PMX_OFS_B_DIR: rd_word = 32'(b_dir_reg);
            PMX_OFS_B_PULL: rd_word = 32'(b_pull_reg);
            PMX_OFS_B_DATA: rd_word = 32'(b_data_reg);
            PMX_OFS_B_PIN: rd_word = 32'(b_level);
            PMX_OFS_C_FUNC: rd_word = 32'(c_func_reg);
            PMX_OFS_C_DIR: rd_word = 32'(c_dir_reg);
            PMX_OFS_C_PULL: rd_word = 32'(c_pull_reg);
            PMX_OFS_C_DATA: rd_word = 32'(c_data_reg);
            PMX_OFS_C_PIN: rd_word = 32'(c_level);
            PMX_OFS_RADIO: rd_word = 32'(rc_reg);
            default: rd_word = 32'h00000000;
        endcase
    end

    // A request is answered on the second edge: waitrequest drops for one cycle and the write lands there.
    always_comb begin
        wr_word = pmx_merge(rd_word, avs_writedata, avs_byteenable);
        b_func_next = b_func_reg;
        b_dir_next = b_dir_reg;
        b_pull_next = b_pull_reg;
        b_data_next = b_data_reg;
        c_func_next = c_func_reg;
        c_dir_next = c_dir_reg;
        c_pull_next = c_pull_reg;
        c_data_next = c_data_reg;
        rc_next = rc_reg;
        wait_next = 1'b1;
        rdata_next = rdata_reg;
        if ((avs_read || avs_write) && wait_reg) begin
            wait_next = 1'b0;
            if (avs_read) begin
                rdata_next = rd_word;
            end
        end
        if (avs_write && !wait_reg) begin
            case (avs_address)
                PMX_OFS_B_FUNC: b_func_next = wr_word[BFW-1:0];
                PMX_OFS_B_DIR: b_dir_next = wr_word[PMX_B_PINS-1:0];
                PMX_OFS_B_PULL: b_pull_next = wr_word[PMX_B_PINS-1:0];
                PMX_OFS_B_DATA: b_data_next = wr_word[PMX_B_PINS-1:0];
                PMX_OFS_C_FUNC: c_func_next = wr_word[CFW-1:0];
                PMX_OFS_C_DIR: c_dir_next = wr_word[PMX_C_PINS-1:0];
                PMX_OFS_C_PULL: c_pull_next = wr_word[PMX_C_PINS-1:0];
                PMX_OFS_C_DATA: c_data_next = wr_word[PMX_C_PINS-1:0];
                PMX_OFS_RADIO: rc_next = wr_word[PMX_RC_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            b_func_reg <= PMX_RST_FUNC_B;
            b_dir_reg <= PMX_RST_DIR_B;
            b_pull_reg <= PMX_RST_PULL_B;
            b_data_reg <= PMX_RST_DATA_B;
            c_func_reg <= PMX_RST_FUNC_C;
            c_dir_reg <= PMX_RST_DIR_C;
            c_pull_reg <= PMX_RST_PULL_C;
            c_data_reg <= PMX_RST_DATA_C;
            rc_reg <= PMX_RST_RC;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            b_func_reg <= b_func_next;
            b_dir_reg <= b_dir_next;
            b_pull_reg <= b_pull_next;
            b_data_reg <= b_data_next;
            c_func_reg <= c_func_next;
            c_dir_reg <= c_dir_next;
            c_pull_reg <= c_pull_next;
            c_data_reg <= c_data_next;
            rc_reg <= rc_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;

    // Port B: bits 0..5 are the audio port in normal function, I/O lines 0..5 in general I/O function and the radio test port in second function.
    for (genvar i = 0; i < PMX_B_PINS; i++) begin : g_pin_b
        pmx_pin_cell u_cell (
            .clock(clock),
            .rst_n(rst_n),
            .func_code(b_func_reg[PMX_FUNC_W*i +: PMX_FUNC_W]),
            .gpio_dir(b_dir_reg[i]),
            .gpio_data(b_data_reg[i]),
            .pull_en(b_pull_reg[i]),
            .norm_out(port_b_norm_out[i]),
            .norm_oe(port_b_norm_oe[i]),
            .alt2_out(b_alt2_out_all[i]),
            .alt2_oe(b_alt2_oe_all[i]),
            .pad_in(port_b_pad_in[i]),
            .pad_out(port_b_pad_out[i]),
            .pad_oe(port_b_pad_oe[i]),
            .pad_pull_en(port_b_pad_pull_en[i]),
            .norm_in(port_b_norm_in[i]),
            .alt2_in(port_b_alt2_in[i]),
            .pad_level(b_level[i])
        );
    end

    for (genvar i = 0; i < PMX_C_PINS; i++) begin : g_pin_c
        pmx_pin_cell u_cell (
            .clock(clock),
            .rst_n(rst_n),
            .func_code(c_func_reg[PMX_FUNC_W*i +: PMX_FUNC_W]),
            .gpio_dir(c_dir_reg[i]),
            .gpio_data(c_data_reg[i]),
            .pull_en(c_pull_reg[i]),
            .norm_out(port_c_norm_out[i]),
            .norm_oe(port_c_norm_oe[i]),
            .alt2_out(port_c_alt2_out[i]),
            .alt2_oe(port_c_alt2_oe[i]),
            .pad_in(port_c_pad_in[i]),
            .pad_out(port_c_pad_out[i]),
            .pad_oe(port_c_pad_oe[i]),
            .pad_pull_en(port_c_pad_pull_en[i]),
            .norm_in(port_c_norm_in[i]),
            .alt2_in(port_c_alt2_in[i]),
            .pad_level(c_level[i])
        );
    end

    pmx_radio_ctrl u_radio (
        .clock(clock),
        .rst_n(rst_n),
        .role_a_code(rc_reg[PMX_RC_ROLE_A_LSB +: PMX_ROLE_W]),
        .role_b_code(rc_reg[PMX_RC_ROLE_B_LSB +: PMX_ROLE_W]),
        .general_output_0(rc_reg[PMX_RC_GENERAL_OUTPUT_0_BIT]),
        .general_output_1(rc_reg[PMX_RC_GENERAL_OUTPUT_1_BIT]),
        .transmit_enable(transmit_enable),
        .amplifier_enable_out(amplifier_enable_out),
        .pulse_mod_out_0(pulse_mod_out_0),
        .pulse_mod_out_1(pulse_mod_out_1),
        .radio_ctrl_out_a(radio_ctrl_out_a),
        .radio_ctrl_out_b(radio_ctrl_out_b)
    );
endmodule : pmx_port_pin_mux

// ===== pmx_pkg.sv
package pmx_pkg;
    localparam int PMX_B_PINS = 14;
    localparam int PMX_C_PINS = 13;
    localparam int PMX_FUNC_W = 2;
    localparam int PMX_ROLE_W = 2;
    localparam int PMX_RC_W = 6;
    localparam int PMX_TP_PINS = 6;

    // Word-aligned byte offsets on the register bus.
    localparam logic [7:0] PMX_OFS_B_FUNC = 8'h00;
    localparam logic [7:0] PMX_OFS_B_DIR = 8'h04;
    localparam logic [7:0] PMX_OFS_B_PULL = 8'h08;
    localparam logic [7:0] PMX_OFS_B_DATA = 8'h0c;
    localparam logic [7:0] PMX_OFS_B_PIN = 8'h10;
    localparam logic [7:0] PMX_OFS_C_FUNC = 8'h14;
    localparam logic [7:0] PMX_OFS_C_DIR = 8'h18;
    localparam logic [7:0] PMX_OFS_C_PULL = 8'h1c;
    localparam logic [7:0] PMX_OFS_C_DATA = 8'h20;
    localparam logic [7:0] PMX_OFS_C_PIN = 8'h24;
    localparam logic [7:0] PMX_OFS_RADIO = 8'h28;

    // Port B bit positions of the audio port signals in normal function.
    localparam int PMX_AUD_TX_CLK = 0;
    localparam int PMX_AUD_TX_FS = 1;
    localparam int PMX_AUD_TX_DATA = 2;
    localparam int PMX_AUD_RX_CLK = 3;
    localparam int PMX_AUD_RX_FS = 4;
    localparam int PMX_AUD_RX_DATA = 5;

    // Radio control register fields.
    localparam int PMX_RC_ROLE_A_LSB = 0;
    localparam int PMX_RC_ROLE_B_LSB = 2;
    localparam int PMX_RC_GENERAL_OUTPUT_0_BIT = 4;
    localparam int PMX_RC_GENERAL_OUTPUT_1_BIT = 5;

    localparam logic [27:0] PMX_RST_FUNC_B = 28'h0000000;
    localparam logic [25:0] PMX_RST_FUNC_C = 26'h0000000;
    localparam logic [13:0] PMX_RST_DIR_B = 14'h0000;
    localparam logic [12:0] PMX_RST_DIR_C = 13'h0000;
    localparam logic [13:0] PMX_RST_PULL_B = 14'h3fff;
    localparam logic [12:0] PMX_RST_PULL_C = 13'h1fff;
    localparam logic [13:0] PMX_RST_DATA_B = 14'h0000;
    localparam logic [12:0] PMX_RST_DATA_C = 13'h0000;
    localparam logic [5:0] PMX_RST_RC = 6'h00;
    localparam logic PMX_RST_PULL_BIT = 1'b1;
    localparam logic PMX_IDLE_IN = 1'b1;
    localparam logic [5:0] PMX_TP_OE = 6'h3f;

    typedef enum logic [1:0] {
        PMX_FN_NORMAL = 2'h0,
        PMX_FN_GPIO = 2'h1,
        PMX_FN_ALT2 = 2'h2
    } pmx_func_t;

    typedef enum logic [1:0] {
        PMX_ROLE_PRIMARY = 2'h0,
        PMX_ROLE_PWM = 2'h1,
        PMX_ROLE_GPO = 2'h2
    } pmx_role_t;

    // The unused code 3 falls back to the safe normal function.
    function automatic pmx_func_t pmx_decode_func(input logic [1:0] code);
        pmx_func_t f;
        if (code == 2'h3) begin
            f = PMX_FN_NORMAL;
        end else begin
            f = pmx_func_t'(code);
        end
        return f;
    endfunction : pmx_decode_func

    // The unused code 3 falls back to the primary role.
    function automatic pmx_role_t pmx_decode_role(input logic [1:0] code);
        pmx_role_t r;
        if (code == 2'h3) begin
            r = PMX_ROLE_PRIMARY;
        end else begin
            r = pmx_role_t'(code);
        end
        return r;
    endfunction : pmx_decode_role
endpackage : pmx_pkg

// ===== pmx_pin_cell.sv
`timescale 1ns/1ns
module pmx_pin_cell
    import pmx_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] func_code,
    input wire logic gpio_dir,
    input wire logic gpio_data,
    input wire logic pull_en,
    input wire logic norm_out,
    input wire logic norm_oe,
    input wire logic alt2_out,
    input wire logic alt2_oe,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_pull_en,
    output logic norm_in,
    output logic alt2_in,
    output logic pad_level
);
    logic meta_reg;
    logic sync_reg;
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;
    logic pull_reg;
    logic pull_next;
    logic norm_in_reg;
    logic norm_in_next;
    logic alt2_in_reg;
    logic alt2_in_next;
    pmx_func_t fn;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_reg <= PMX_IDLE_IN;
            sync_reg <= PMX_IDLE_IN;
        end else begin
            meta_reg <= pad_in;
            sync_reg <= meta_reg;
        end
    end

    always_comb begin
        fn = pmx_decode_func(func_code);
        out_next = norm_out;
        oe_next = norm_oe;
        norm_in_next = PMX_IDLE_IN;
        alt2_in_next = PMX_IDLE_IN;
        pull_next = pull_en;
        unique case (fn)
            PMX_FN_NORMAL: begin
                out_next = norm_out;
                oe_next = norm_oe;
                norm_in_next = sync_reg;
            end
            PMX_FN_GPIO: begin
                out_next = gpio_data;
                oe_next = gpio_dir;
            end
            PMX_FN_ALT2: begin
                out_next = alt2_out;
                oe_next = alt2_oe;
                alt2_in_next = sync_reg;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_reg <= 1'b0;
            oe_reg <= 1'b0;
            pull_reg <= PMX_RST_PULL_BIT;
            norm_in_reg <= PMX_IDLE_IN;
            alt2_in_reg <= PMX_IDLE_IN;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            pull_reg <= pull_next;
            norm_in_reg <= norm_in_next;
            alt2_in_reg <= alt2_in_next;
        end
    end

    assign pad_out = out_reg;
    assign pad_oe = oe_reg;
    assign pad_pull_en = pull_reg;
    assign norm_in = norm_in_reg;
    assign alt2_in = alt2_in_reg;
    assign pad_level = sync_reg;
endmodule : pmx_pin_cell

// ===== pmx_radio_ctrl.sv
`timescale 1ns/1ns
module pmx_radio_ctrl
    import pmx_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] role_a_code,
    input wire logic [1:0] role_b_code,
    input wire logic general_output_0,
    input wire logic general_output_1,
    input wire logic transmit_enable,
    input wire logic amplifier_enable_out,
    input wire logic pulse_mod_out_0,
    input wire logic pulse_mod_out_1,
    output logic radio_ctrl_out_a,
    output logic radio_ctrl_out_b
);
    logic out_a_reg;
    logic out_a_next;
    logic out_b_reg;
    logic out_b_next;

    function automatic logic pmx_pick(input logic [1:0] code, input logic prim, input logic pwm, input logic gpo);
        logic v;
        v = prim;
        unique case (pmx_decode_role(code))
            PMX_ROLE_PRIMARY: v = prim;
            PMX_ROLE_PWM: v = pwm;
            PMX_ROLE_GPO: v = gpo;
        endcase
        return v;
    endfunction : pmx_pick

    always_comb begin
        out_a_next = pmx_pick(role_a_code, transmit_enable, pulse_mod_out_0, general_output_0);
        out_b_next = pmx_pick(role_b_code, amplifier_enable_out, pulse_mod_out_1, general_output_1);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            out_a_reg <= 1'b0;
            out_b_reg <= 1'b0;
        end else begin
            out_a_reg <= out_a_next;
            out_b_reg <= out_b_next;
        end
    end

    assign radio_ctrl_out_a = out_a_reg;
    assign radio_ctrl_out_b = out_b_reg;
endmodule : pmx_radio_ctrl

// ===== pmx_port_pin_mux_assertions.sv
`timescale 1ns/1ns
module pmx_port_pin_mux_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [13:0] port_b_pad_in,
    input wire logic [13:0] port_b_pad_oe,
    input wire logic [13:0] port_b_pad_pull_en,
    input wire logic [13:0] port_b_norm_in,
    input wire logic [13:0] port_b_alt2_in,
    input wire logic [12:0] port_c_pad_in,
    input wire logic [12:0] port_c_norm_in,
    input wire logic [12:0] port_c_alt2_in,
    input wire logic radio_ctrl_out_a,
    input wire logic radio_ctrl_out_b
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered on the next cycle");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer without a request");
    a_readdata_hold: assert property ($past(avs_waitrequest) && avs_waitrequest |-> $stable(avs_readdata))
        else $error("read data changed outside a read answer");
    a_reset_state: assert property (disable iff (1'b0) !rst_n |=> port_b_pad_oe == 14'h0000
        && port_b_pad_pull_en == 14'h3fff && avs_waitrequest && !radio_ctrl_out_a && !radio_ctrl_out_b)
        else $error("pad controls not at their reset state");
    a_route_excl: assert property ({port_c_norm_in | port_c_alt2_in, port_b_norm_in | port_b_alt2_in}
        == 27'h7ffffff) else $error("pad level routed to both peripherals of a pin");
    a_b_in_sync: assert property ($past(rst_n, 3) |->
        (~(port_b_norm_in & port_b_alt2_in) & $past(port_b_pad_in, 3)) == 14'h0000)
        else $error("port B routed input does not follow the pad three cycles earlier");
    a_c_in_sync: assert property ($past(rst_n, 3) |->
        (~(port_c_norm_in & port_c_alt2_in) & $past(port_c_pad_in, 3)) == 13'h0000)
        else $error("port C routed input does not follow the pad three cycles earlier");
    a_pull_by_write: assert property ($changed(port_b_pad_pull_en) |-> $past(avs_write, 2))
        else $error("pull-up enable changed without a register write");
endmodule : pmx_port_pin_mux_assertions

bind pmx_port_pin_mux pmx_port_pin_mux_assertions u_chk (.clock, .rst_n, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .port_b_pad_in, .port_b_pad_oe, .port_b_pad_pull_en, .port_b_norm_in, .port_b_alt2_in,
    .port_c_pad_in, .port_c_norm_in, .port_c_alt2_in, .radio_ctrl_out_a, .radio_ctrl_out_b);

// ===== pmx_pad_model.sv
`timescale 1ns/1ns
module pmx_pad_model #(
    parameter int W = 14
) (
    input wire logic clock,
    input wire logic [W-1:0] pad_out,
    input wire logic [W-1:0] pad_oe,
    input wire logic [W-1:0] pad_pull_en,
    input wire logic [W-1:0] ext_level,
    input wire logic [W-1:0] ext_oe,
    output logic [W-1:0] pad_in
);
    logic [W-1:0] float_lvl = '0;
    // A pin that nobody drives and nothing pulls has no level, so it toggles every cycle.
    always @(posedge clock) float_lvl <= ~float_lvl;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pad_oe[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_oe[i]) begin
                pad_in[i] = ext_level[i];
            end else if (pad_pull_en[i]) begin
                pad_in[i] = 1'b1;
            end else begin
                pad_in[i] = float_lvl[i];
            end
        end
    end
endmodule : pmx_pad_model

// ===== port_pin_function_mux_bench.sv
`timescale 1ns/1ns
module port_pin_function_mux_bench
    import pmx_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, rdq;
    logic avs_waitrequest, radio_ctrl_out_a, radio_ctrl_out_b;
    logic [13:0] port_b_pad_in, port_b_pad_out, port_b_pad_oe, port_b_pad_pull_en, port_b_norm_in, port_b_alt2_in;
    logic [13:0] port_b_norm_out = '0, port_b_norm_oe = '0, ext_b = '0, ext_b_oe = '0;
    logic [13:6] port_b_alt2_out = '0, port_b_alt2_oe = '0;
    logic [5:0] radio_test_port = '0;
    logic [12:0] port_c_pad_in, port_c_pad_out, port_c_pad_oe, port_c_pad_pull_en, port_c_norm_in, port_c_alt2_in;
    logic [12:0] port_c_norm_out = '0, port_c_norm_oe = '0, port_c_alt2_out = '0, port_c_alt2_oe = '0;
    logic [12:0] ext_c = '0, ext_c_oe = '0;
    logic transmit_enable = 1'b0, amplifier_enable_out = 1'b0, pulse_mod_out_0 = 1'b0, pulse_mod_out_1 = 1'b0;
    int n_errors = 0;
    int check_count = 0;

    pmx_port_pin_mux DUT (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .port_b_pad_in, .port_b_pad_out, .port_b_pad_oe, .port_b_pad_pull_en,
        .port_b_norm_out, .port_b_norm_oe, .port_b_norm_in, .port_b_alt2_out, .port_b_alt2_oe, .port_b_alt2_in,
        .radio_test_port, .port_c_pad_in, .port_c_pad_out, .port_c_pad_oe, .port_c_pad_pull_en, .port_c_norm_out,
        .port_c_norm_oe, .port_c_norm_in, .port_c_alt2_out, .port_c_alt2_oe, .port_c_alt2_in, .transmit_enable,
        .amplifier_enable_out, .pulse_mod_out_0, .pulse_mod_out_1, .radio_ctrl_out_a, .radio_ctrl_out_b);
    pmx_pad_model #(.W(14)) u_pad_b (.clock, .pad_out(port_b_pad_out), .pad_oe(port_b_pad_oe),
        .pad_pull_en(port_b_pad_pull_en), .ext_level(ext_b), .ext_oe(ext_b_oe), .pad_in(port_b_pad_in));
    pmx_pad_model #(.W(13)) u_pad_c (.clock, .pad_out(port_c_pad_out), .pad_oe(port_c_pad_oe),
        .pad_pull_en(port_c_pad_pull_en), .ext_level(ext_c), .ext_oe(ext_c_oe), .pad_in(port_c_pad_in));

    initial begin
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0 && t < 50) begin
            @(posedge clock);
            t++;
        end
        if (t == 50) n_errors++;
        rdq = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdq, exp);
    endtask : rdchk

    // Lands just after the next edge, where registered outputs have settled.
    task automatic step;
        @(posedge clock);
        #1;
    endtask : step

    task automatic test_reset;
        #1;
        chk(port_b_pad_oe | port_c_pad_oe, 32'h0);
        chk({port_c_pad_pull_en, port_b_pad_pull_en}, {13'h1fff, 14'h3fff});
        chk({port_c_norm_in, port_b_alt2_in}, {13'h1fff, 14'h3fff});
        chk({radio_ctrl_out_a, radio_ctrl_out_b, avs_waitrequest}, 32'h1);
        @(posedge clock);
        rst_n <= 1'b1;
        rdchk(PMX_OFS_B_FUNC, 32'h0);
        rdchk(PMX_OFS_C_PULL, 32'h1fff);
        rdchk(PMX_OFS_RADIO, 32'h0);
    endtask : test_reset

    task automatic test_refused;
        bus(1'b1, 8'h3c, 32'hffffffff);
        rdchk(8'h3c, 32'h0);
        bus(1'b1, PMX_OFS_B_PIN, 32'h0);
        rdchk(PMX_OFS_B_PIN, 32'h3fff);
        bus(1'b1, PMX_OFS_C_DATA, 32'hffffffff);
        rdchk(PMX_OFS_C_DATA, 32'h1fff);
        avs_byteenable <= 4'h1;
        bus(1'b1, PMX_OFS_B_DIR, 32'h0000ffff);
        avs_byteenable <= 4'hf;
        rdchk(PMX_OFS_B_DIR, 32'h00ff);
        bus(1'b1, PMX_OFS_B_PULL, 32'h3ffe);
    endtask : test_refused

    task automatic test_normal;
        @(posedge clock);
        port_b_norm_out <= 14'h2a5c;
        port_b_norm_oe <= 14'h3f0f;
        port_c_norm_out <= 13'h1337;
        port_c_norm_oe <= 13'h00ff;
        ext_b <= 14'h00a0;
        ext_b_oe <= 14'h00f0;
        ext_c <= 13'h1500;
        ext_c_oe <= 13'h1f00;
        step;
        chk({port_b_pad_oe, port_b_pad_out}, {14'h3f0f, 14'h2a5c});
        chk({port_c_pad_oe, port_c_pad_out}, {13'h00ff, 13'h1337});
        repeat (3) step;
        chk({port_b_norm_in, port_b_alt2_in}, {(14'h2a5c & 14'h3f0f) | 14'h00a0, 14'h3fff});
        chk(port_c_norm_in, (13'h1337 & 13'h00ff) | 13'h1500);
    endtask : test_normal

    task automatic test_gpio;
        bus(1'b1, PMX_OFS_B_DATA, 32'h1234);
        bus(1'b1, PMX_OFS_B_DIR, 32'h0f0f);
        bus(1'b1, PMX_OFS_B_FUNC, 32'h05555555);
        step;
        chk({port_b_pad_oe, port_b_pad_out & 14'h0f0f}, {14'h0f0f, 14'h0204});
        repeat (3) step;
        chk({port_b_norm_in, port_b_alt2_in}, 32'h0fffffff);
        rdchk(PMX_OFS_B_PIN, 32'h32a4);
        bus(1'b1, PMX_OFS_B_DIR, 32'h3000);
        step;
        chk(port_b_pad_oe, 32'h3000);
    endtask : test_gpio

    task automatic test_alt2;
        @(posedge clock);
        radio_test_port <= 6'h29;
        port_b_alt2_out <= 8'hc3;
        port_b_alt2_oe <= 8'h0f;
        ext_b <= 14'h2800;
        ext_b_oe <= 14'h3c00;
        bus(1'b1, PMX_OFS_B_FUNC, 32'h0aaaaaaa);
        step;
        chk({port_b_pad_oe, port_b_pad_out}, {14'h03ff, 8'hc3, 6'h29});
        repeat (3) step;
        chk({port_b_alt2_in, port_b_norm_in}, {14'h2800 | (14'h03ff & {8'hc3, 6'h29}), 14'h3fff});
    endtask : test_alt2

    task automatic test_mixed;
        logic [31:0] f;
        logic [12:0] o, e;
        f = 32'h0;
        for (int i = 0; i < PMX_C_PINS; i++) begin
            f[2*i +: 2] = 2'(i % 3);
            o[i] = (i % 3 == 0) ? port_c_norm_out[i] : (i % 3 == 1) ? 1'(13'h0a5a >> i) : 1'(13'h0f0f >> i);
            e[i] = (i % 3 == 0) ? port_c_norm_oe[i] : (i % 3 == 1) ? 1'(13'h0aaa >> i) : 1'(13'h0ff0 >> i);
        end
        f[25:24] = 2'h3;
        @(posedge clock);
        port_c_alt2_out <= 13'h0f0f;
        port_c_alt2_oe <= 13'h0ff0;
        bus(1'b1, PMX_OFS_C_DATA, 32'h0a5a);
        bus(1'b1, PMX_OFS_C_DIR, 32'h0aaa);
        bus(1'b1, PMX_OFS_C_FUNC, f);
        step;
        chk({port_c_pad_oe, port_c_pad_out}, {e, o});
        repeat (3) step;
        chk(port_c_alt2_in, 13'h1fdf);
        bus(1'b1, PMX_OFS_C_PULL, 32'h0a5a);
        step;
        chk({port_c_pad_pull_en, port_b_pad_pull_en}, {13'h0a5a, 14'h3ffe});
    endtask : test_mixed

    task automatic test_radio;
        for (int r = 0; r < 4; r++) begin
            @(posedge clock);
            transmit_enable <= (r == 0 || r == 3);
            amplifier_enable_out <= !(r == 0 || r == 3);
            pulse_mod_out_0 <= (r == 1);
            pulse_mod_out_1 <= (r != 1);
            bus(1'b1, PMX_OFS_RADIO, {26'h0, r != 2, r == 2, 2'(r), 2'(r)});
            step;
            chk({radio_ctrl_out_a, radio_ctrl_out_b}, 32'h2);
        end
    endtask : test_radio

    task automatic test_done;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (3) @(posedge clock);
        test_reset();
        test_refused();
        test_normal();
        test_gpio();
        test_alt2();
        test_mixed();
        test_radio();
        test_done();
    end

    initial begin
        #500000;
        n_errors++;
        test_done();
    end
endmodule : port_pin_function_mux_bench
